// *** include/i2cse_pkg.sv ***
// Package for the two-wire control, first status and event block.
// Assumes a 32-bit AHB-Lite register bus and an 8-bit register layout.
package i2cse_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets (byte addresses, one aligned word each)
  localparam logic [7:0] I2CSE_OFS_CTRL = 8'h00;
  localparam logic [7:0] I2CSE_OFS_STAT = 8'h04;

  ////////////////////////////////////////////////////////////////////////////
  // Control register fields
  localparam int I2CSE_CR_ITE   = 0;
  localparam int I2CSE_CR_STOP  = 1;
  localparam int I2CSE_CR_ACK   = 2;
  localparam int I2CSE_CR_START = 3;
  localparam int I2CSE_CR_GENCALL_ENABLE  = 4;
  localparam int I2CSE_CR_PE    = 5;

  // Status register one fields
  localparam int I2CSE_SR_SB    = 0;
  localparam int I2CSE_SR_MSL   = 1;
  localparam int I2CSE_SR_ADDR_MATCH_FLAG  = 2;
  localparam int I2CSE_SR_BTF   = 3;
  localparam int I2CSE_SR_BUSY  = 4;
  localparam int I2CSE_SR_TRA   = 5;
  localparam int I2CSE_SR_HDR   = 6;
  localparam int I2CSE_SR_EVF   = 7;

  localparam logic [7:0] I2CSE_RST_VAL = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Slave address bytes with special meaning
  localparam logic [7:0] I2CSE_GCALL_BYTE  = 8'h00;
  localparam logic [7:0] I2CSE_IGNORE_BYTE = 8'h01;

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite encodings
  localparam logic [1:0] I2CSE_HTRANS_IDLE   = 2'h0;
  localparam logic [1:0] I2CSE_HTRANS_NONSEQ = 2'h2;
  localparam logic       I2CSE_HRESP_OKAY    = 1'b0;

endpackage

// *** rtl/i2cse_ctrl_status.sv ***
// Control register, status register one and event/interrupt logic of a
// multimaster two-wire interface. Assumes a transfer engine on hclk that
// reports events as one-cycle pulses, and raw bus lines from the pins.
`timescale 1ns/1ps

module i2cse_ctrl_status
  import i2cse_pkg::*;
#(
  parameter int HADDR_W = 8
) (
  input  wire logic               hclk,
  input  wire logic               hresetn,
  input  wire logic               hsel,
  input  wire logic [HADDR_W-1:0] haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output      logic               hreadyout,
  output      logic               hresp,
  output      logic [31:0]        hrdata,
  input  wire logic               scl_i,
  input  wire logic               sda_i,
  output      logic               scl_o,
  output      logic               scl_oe_n,
  input  wire logic               halt_mode,
  input  wire logic               wait_mode,
  input  wire logic               cpu_imask,
  input  wire logic               ev_start_sent,
  input  wire logic               ev_header_sent,
  input  wire logic               ev_addr_sent,
  input  wire logic               ev_byte_tx,
  input  wire logic               ev_byte_rx,
  input  wire logic               ev_addr_rx,
  input  wire logic [7:0]         rx_addr_byte,
  input  wire logic               own_addr_hit,
  input  wire logic               ev_stop_sent,
  input  wire logic               ev_ack_fail,
  input  wire logic               ev_stop_seen,
  input  wire logic               ev_arb_lost,
  input  wire logic               ev_bus_error,
  input  wire logic               err_pending,
  input  wire logic               data_reg_wr,
  input  wire logic               data_reg_rd,
  input  wire logic               status_two_rd,
  output      logic               engine_active,
  output      logic               pins_alt_sel,
  output      logic               start_req,
  output      logic               stop_req,
  output      logic               ack_en,
  output      logic               gencall_en,
  output      logic               slave_rx_only,
  output      logic               release_lines,
  output      logic               irq,
  output      logic               wait_exit
);

  // Offsets are byte addresses up to 0x04, and the decode compares 8 bits
  if (HADDR_W < 3 || HADDR_W > 8) begin : g_haddr_chk
    $error("HADDR_W must lie between 3 and 8");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register state
  logic               periph_enable_bit_ff;
  logic               gencall_enable_ff;
  logic               start_bit_ff;
  logic               ack_bit_ff;
  logic               stop_bit_ff;
  logic               irq_enable_ff;
  logic               event_flag_ff;
  logic               header_sent_flag_ff;
  logic               transmitter_flag_ff;
  logic               busy_ff;
  logic               byte_done_flag_ff;
  logic               addr_match_flag_ff;
  logic               master_flag_ff;
  logic               start_sent_flag_ff;
  logic               addr_done_event_ff;
  logic               byte_defer_ff;
  logic               sr1_armed_ff;
  logic               sr2_armed_ff;
  logic               wr_pend_ff;
  logic [HADDR_W-1:0] wr_addr_ff;
  logic               scl_s1_ff;
  logic               scl_s2_ff;
  logic               sda_s1_ff;
  logic               sda_s2_ff;
  logic               sda_s3_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode
  wire               addr_phase = hsel & hready & htrans[1];
  wire               rd_access  = addr_phase & ~hwrite;
  wire               wr_access  = addr_phase & hwrite;
  wire [7:0]         addr_b     = 8'(haddr);
  wire [7:0]         wr_addr_b  = 8'(wr_addr_ff);
  wire               rd_ctrl    = rd_access & (addr_b == I2CSE_OFS_CTRL);
  wire               rd_stat    = rd_access & (addr_b == I2CSE_OFS_STAT);
  // Writes and read side effects are both frozen in halt
  wire               live       = ~halt_mode;
  wire               cr_wr      = wr_pend_ff & live
                                  & (wr_addr_b == I2CSE_OFS_CTRL);
  wire               sr1_rd     = rd_stat & live;
  wire [7:0]         wd         = hwdata[7:0];
  wire               wd_pe      = wd[I2CSE_CR_PE];

  wire [7:0] ctrl_val;
  wire [7:0] stat_val;
  assign ctrl_val[7:6]           = 2'h0;
  assign ctrl_val[I2CSE_CR_PE]    = periph_enable_bit_ff;
  assign ctrl_val[I2CSE_CR_GENCALL_ENABLE]  = gencall_enable_ff;
  assign ctrl_val[I2CSE_CR_START] = start_bit_ff;
  assign ctrl_val[I2CSE_CR_ACK]   = ack_bit_ff;
  assign ctrl_val[I2CSE_CR_STOP]  = stop_bit_ff;
  assign ctrl_val[I2CSE_CR_ITE]   = irq_enable_ff;
  assign stat_val[I2CSE_SR_EVF]   = event_flag_ff;
  assign stat_val[I2CSE_SR_HDR]   = header_sent_flag_ff;
  assign stat_val[I2CSE_SR_TRA]   = transmitter_flag_ff;
  assign stat_val[I2CSE_SR_BUSY]  = busy_ff;
  assign stat_val[I2CSE_SR_BTF]   = byte_done_flag_ff;
  assign stat_val[I2CSE_SR_ADDR_MATCH_FLAG]  = addr_match_flag_ff;
  assign stat_val[I2CSE_SR_MSL]   = master_flag_ff;
  assign stat_val[I2CSE_SR_SB]    = start_sent_flag_ff;

  wire [31:0] rd_mux = rd_ctrl ? {24'h0, ctrl_val} :
                       rd_stat ? {24'h0, stat_val} : 32'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Bus line watcher: start and stop conditions seen on the wires
  // Only the second and third stages are compared, never the first
  wire bus_start = scl_s2_ff & sda_s3_ff & ~sda_s2_ff;
  wire bus_stop  = scl_s2_ff & ~sda_s3_ff & sda_s2_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Read-then-access sequences
  wire seq_dr_wr  = sr1_armed_ff & data_reg_wr & live;
  wire seq_dr_rd  = sr1_armed_ff & data_reg_rd & live;
  wire seq_cr_wr  = sr1_armed_ff & cr_wr;
  wire seq2_dr_wr = sr2_armed_ff & data_reg_wr & live;

  wire nxt_sr1_armed = sr1_rd | (sr1_armed_ff
                       & ~(data_reg_wr | data_reg_rd | cr_wr));
  wire nxt_sr2_armed = (status_two_rd & live)
                       | (sr2_armed_ff & ~data_reg_wr);

  ////////////////////////////////////////////////////////////////////////////
  // Control register next values
  wire pe_on     = periph_enable_bit_ff;
  // First enabling write loads only the enable and stop bits
  wire cr_full   = cr_wr & pe_on & wd_pe;
  wire nxt_pe    = cr_wr ? wd_pe : periph_enable_bit_ff;
  // Disable clears everything but the stop bit
  wire nxt_gencall_enable  = ~nxt_pe ? 1'b0 :
                   cr_full ? wd[I2CSE_CR_GENCALL_ENABLE] : gencall_enable_ff;
  wire nxt_ack   = ~nxt_pe ? 1'b0 :
                   cr_full ? wd[I2CSE_CR_ACK] : ack_bit_ff;
  wire nxt_ite   = ~nxt_pe ? 1'b0 :
                   cr_full ? wd[I2CSE_CR_ITE] : irq_enable_ff;
  // A start sent in the same cycle as a rewrite wins over it
  wire nxt_start = ~nxt_pe | ev_start_sent ? 1'b0 :
                   cr_full ? wd[I2CSE_CR_START] : start_bit_ff;
  wire stop_done = ev_stop_sent & master_flag_ff;
  wire nxt_stop  = stop_done ? 1'b0 :
                   cr_wr ? wd[I2CSE_CR_STOP] : stop_bit_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Status flag next values (set wins over clear; disable wins over all)
  wire addr_ok   = ev_addr_rx & (
                   (own_addr_hit & (rx_addr_byte != I2CSE_IGNORE_BYTE))
                   | (gencall_enable_ff
                      & (rx_addr_byte == I2CSE_GCALL_BYTE)));
  wire nxt_addr_match_flag  = nxt_pe & (addr_ok
                   | (addr_match_flag_ff & ~sr1_rd));
  wire nxt_sb    = nxt_pe & (ev_start_sent
                   | (start_sent_flag_ff & ~seq_dr_wr));
  wire nxt_hdr   = nxt_pe & (ev_header_sent
                   | (header_sent_flag_ff & ~seq2_dr_wr));
  wire nxt_ev6   = nxt_pe & (ev_addr_sent
                   | (addr_done_event_ff & ~seq_cr_wr));
  wire ev6_end   = addr_done_event_ff & seq_cr_wr;
  // A sent address byte reports byte done only after its address event
  wire defer_tx  = ev_byte_tx & (addr_done_event_ff | ev_addr_sent);
  wire nxt_defer = nxt_pe & (defer_tx | (byte_defer_ff & ~ev6_end));
  wire tx_done   = (ev_byte_tx & ~defer_tx) | (byte_defer_ff & ev6_end);
  wire rx_done   = ev_byte_rx & ack_bit_ff;
  wire btf_clr   = transmitter_flag_ff ? seq_dr_wr : seq_dr_rd;
  wire nxt_btf   = nxt_pe & (tx_done | rx_done
                   | (byte_done_flag_ff & ~btf_clr));
  wire nxt_tra   = nxt_pe & (tx_done | (transmitter_flag_ff
                   & ~btf_clr & ~bus_stop & ~ev_stop_seen
                   & ~ev_arb_lost & ~rx_done));
  wire nxt_busy  = nxt_pe & (bus_start
                   | (busy_ff & ~bus_stop & ~ev_bus_error));
  wire msl_set   = cr_full & wd[I2CSE_CR_START];
  wire nxt_msl   = nxt_pe & (msl_set | (master_flag_ff
                   & ~bus_stop & ~ev_arb_lost));

  wire ev_any    = ev_start_sent | ev_header_sent | ev_addr_sent
                   | tx_done | rx_done | addr_ok | ev_ack_fail
                   | ev_stop_seen | ev_arb_lost | ev_bus_error;
  // The event flag lasts while any source is still pending
  wire ev_hold   = nxt_hdr | nxt_btf | nxt_addr_match_flag | nxt_sb | nxt_ev6
                   | (err_pending & ~(status_two_rd & live));
  wire nxt_evf   = nxt_pe & (ev_any
                   | (event_flag_ff & ev_hold));

  ////////////////////////////////////////////////////////////////////////////
  // Outputs toward the engine, the pins and the CPU
  wire hold_scl  = header_sent_flag_ff | start_sent_flag_ff
                   | byte_done_flag_ff | addr_match_flag_ff
                   | addr_done_event_ff;
  wire run       = periph_enable_bit_ff & live;
  wire nxt_irq   = run & event_flag_ff & irq_enable_ff & ~cpu_imask;

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave: always ready, reads registered at the address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout  <= 1'b0;
      hresp      <= I2CSE_HRESP_OKAY;
      hrdata     <= 32'h0;
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= '0;
    end else begin
      hreadyout  <= 1'b1;
      hresp      <= I2CSE_HRESP_OKAY;
      wr_pend_ff <= wr_access;
      if (addr_phase) begin
        wr_addr_ff <= haddr;
      end
      if (rd_access) begin
        hrdata <= rd_mux;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Two-flop synchronisers on the bus lines
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      scl_s1_ff <= 1'b1;
      scl_s2_ff <= 1'b1;
      sda_s1_ff <= 1'b1;
      sda_s2_ff <= 1'b1;
      sda_s3_ff <= 1'b1;
    end else begin
      scl_s1_ff <= scl_i;
      scl_s2_ff <= scl_s1_ff;
      sda_s1_ff <= sda_i;
      sda_s2_ff <= sda_s1_ff;
      sda_s3_ff <= sda_s2_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control register, frozen in halt
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      periph_enable_bit_ff <= I2CSE_RST_VAL[I2CSE_CR_PE];
      gencall_enable_ff    <= I2CSE_RST_VAL[I2CSE_CR_GENCALL_ENABLE];
      start_bit_ff         <= I2CSE_RST_VAL[I2CSE_CR_START];
      ack_bit_ff           <= I2CSE_RST_VAL[I2CSE_CR_ACK];
      stop_bit_ff          <= I2CSE_RST_VAL[I2CSE_CR_STOP];
      irq_enable_ff        <= I2CSE_RST_VAL[I2CSE_CR_ITE];
    end else if (live) begin
      periph_enable_bit_ff <= nxt_pe;
      gencall_enable_ff    <= nxt_gencall_enable;
      start_bit_ff         <= nxt_start;
      ack_bit_ff           <= nxt_ack;
      stop_bit_ff          <= nxt_stop;
      irq_enable_ff        <= nxt_ite;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status register one and hidden sequence state, frozen in halt
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      event_flag_ff       <= I2CSE_RST_VAL[I2CSE_SR_EVF];
      header_sent_flag_ff <= I2CSE_RST_VAL[I2CSE_SR_HDR];
      transmitter_flag_ff <= I2CSE_RST_VAL[I2CSE_SR_TRA];
      busy_ff             <= I2CSE_RST_VAL[I2CSE_SR_BUSY];
      byte_done_flag_ff   <= I2CSE_RST_VAL[I2CSE_SR_BTF];
      addr_match_flag_ff  <= I2CSE_RST_VAL[I2CSE_SR_ADDR_MATCH_FLAG];
      master_flag_ff      <= I2CSE_RST_VAL[I2CSE_SR_MSL];
      start_sent_flag_ff  <= I2CSE_RST_VAL[I2CSE_SR_SB];
    end else if (live) begin
      event_flag_ff       <= nxt_evf;
      header_sent_flag_ff <= nxt_hdr;
      transmitter_flag_ff <= nxt_tra;
      busy_ff             <= nxt_busy;
      byte_done_flag_ff   <= nxt_btf;
      addr_match_flag_ff  <= nxt_addr_match_flag;
      master_flag_ff      <= nxt_msl;
      start_sent_flag_ff  <= nxt_sb;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_done_event_ff <= 1'b0;
      byte_defer_ff      <= 1'b0;
      sr1_armed_ff       <= 1'b0;
      sr2_armed_ff       <= 1'b0;
    end else if (live) begin
      addr_done_event_ff <= nxt_ev6;
      byte_defer_ff      <= nxt_defer;
      sr1_armed_ff       <= nxt_sr1_armed;
      sr2_armed_ff       <= nxt_sr2_armed;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      scl_o         <= 1'b0;
      scl_oe_n      <= 1'b1;
      engine_active <= 1'b0;
      pins_alt_sel  <= 1'b0;
      start_req     <= 1'b0;
      stop_req      <= 1'b0;
      ack_en        <= 1'b0;
      gencall_en    <= 1'b0;
      slave_rx_only <= 1'b0;
      release_lines <= 1'b0;
      irq           <= 1'b0;
      wait_exit     <= 1'b0;
    end else begin
      // Open drain: the clock is only ever pulled low
      scl_o         <= 1'b0;
      scl_oe_n      <= ~(run & hold_scl);
      engine_active <= run;
      pins_alt_sel  <= periph_enable_bit_ff;
      start_req     <= run & start_bit_ff
                       & (master_flag_ff | ~busy_ff);
      stop_req      <= run & stop_bit_ff & master_flag_ff;
      ack_en        <= run & ack_bit_ff;
      gencall_en    <= run & gencall_enable_ff;
      slave_rx_only <= run & gencall_enable_ff & ~master_flag_ff;
      release_lines <= ~periph_enable_bit_ff
                       | (stop_bit_ff & ~master_flag_ff
                          & byte_done_flag_ff);
      irq           <= nxt_irq;
      wait_exit     <= nxt_irq & wait_mode;
    end
  end

  // hsize is accepted as any size; every register sits in the low byte
  wire unused_ok = ^hsize | ^hwdata[31:8] | htrans[0];

endmodule

// *** bench/i2cse_asserts.sv ***
// Checker for the control, status and event block, ports only.
// Assumes one hclk domain and the async active-low hresetn.
`timescale 1ns/1ps
module i2cse_asserts (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic halt_mode,
  input wire logic wait_mode,
  input wire logic cpu_imask,
  input wire logic ev_start_sent,
  input wire logic scl_oe_n,
  input wire logic engine_active,
  input wire logic pins_alt_sel,
  input wire logic start_req,
  input wire logic stop_req,
  input wire logic ack_en,
  input wire logic gencall_en,
  input wire logic slave_rx_only,
  input wire logic release_lines,
  input wire logic irq,
  input wire logic wait_exit
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Flag lands one edge after the pulse, the pin one edge later
  sequence s_start;
    ev_start_sent && engine_active && !halt_mode;
  endsequence
  a_start_hold: assert property (s_start |-> ##2 !scl_oe_n)
    else $error("clock line not held after start");
  a_irq_mask: assert property (cpu_imask |=> !irq)
    else $error("interrupt while masked");
  a_wait_exit: assert property (wait_exit |-> irq && $past(wait_mode))
    else $error("wait exit without interrupt");
  a_halt_quiet: assert property (halt_mode |=> !engine_active && !irq)
    else $error("activity in halt");
  a_off_clear: assert property (!pins_alt_sel |->
    !gencall_en && !ack_en && !start_req && !irq)
    else $error("control active while disabled");
  a_gc_rxonly: assert property (slave_rx_only |-> gencall_en)
    else $error("receive-only without general call");
  a_stop_master: assert property (stop_req |-> !release_lines)
    else $error("master stop released lines");
  a_start_run: assert property (start_req |-> engine_active)
    else $error("start request while idle");
endmodule
bind i2cse_ctrl_status i2cse_asserts u_chk (.hclk, .hresetn, .halt_mode,
  .wait_mode, .cpu_imask, .ev_start_sent, .scl_oe_n, .engine_active,
  .pins_alt_sel, .start_req, .stop_req, .ack_en, .gencall_en,
  .slave_rx_only, .release_lines, .irq, .wait_exit);

// *** bench/i2cse_bus_peer.sv ***
// Another master on the two-wire bus, making start and stop.
// Assumes pulled-up lines; the clock stands still outside frames.
`timescale 1ns/1ps
module i2cse_bus_peer (
  output logic scl,
  output logic sda
);
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  // Data falls while clock high, then clock low: 64 ns link period
  task automatic start_cond();
    #32 sda = 1'b0;
    #32 scl = 1'b0;
  endtask
  task automatic stop_cond();
    sda = 1'b0;
    #32 scl = 1'b1;
    #32 sda = 1'b1;
  endtask
endmodule

// *** bench/testbench.sv ***
// Register-level bench for the control, status and event block.
// Assumes a zero-wait AHB-Lite slave and one-cycle engine pulses.
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin fail_count++; \
  $display("unexpected t=%0t got=%h exp=%h", $time, (g), (e)); end end
module testbench;
  import i2cse_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, halt_mode, wait_mode, cpu_imask;
  logic [7:0]  haddr, rx_addr_byte;
  logic [1:0]  htrans;
  logic [31:0] hwdata, rd_data;
  logic [13:0] ev;
  logic        own_addr_hit, err_pend;
  wire         hreadyout, hresp, scl_i, sda_i, scl_o, scl_oe_n, eng, alt;
  wire         start_req, stop_req, ack_en, gc_en, rx_only, rel, irq, wexit;
  wire  [31:0] hrdata;
  int          fail_count, compares, cyc;
  ////////////////////////////////////////////////////////////////////////////
  i2cse_bus_peer peer (.scl(scl_i), .sda(sda_i));
  i2cse_ctrl_status dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .scl_i(scl_i), .sda_i(sda_i),
    .scl_o(scl_o), .scl_oe_n(scl_oe_n), .halt_mode(halt_mode),
    .wait_mode(wait_mode), .cpu_imask(cpu_imask), .ev_start_sent(ev[0]),
    .ev_header_sent(ev[1]), .ev_addr_sent(ev[2]), .ev_byte_tx(ev[3]),
    .ev_byte_rx(ev[4]), .ev_addr_rx(ev[5]), .rx_addr_byte(rx_addr_byte),
    .own_addr_hit(own_addr_hit), .ev_stop_sent(ev[6]),
    .ev_ack_fail(ev[7]), .ev_stop_seen(ev[8]), .ev_arb_lost(ev[9]),
    .ev_bus_error(ev[10]), .err_pending(err_pend), .data_reg_wr(ev[11]),
    .data_reg_rd(ev[12]), .status_two_rd(ev[13]), .engine_active(eng),
    .pins_alt_sel(alt), .start_req(start_req), .stop_req(stop_req),
    .ack_en(ack_en), .gencall_en(gc_en), .slave_rx_only(rx_only),
    .release_lines(rel), .irq(irq), .wait_exit(wexit));
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  // Generous ceiling; the whole sequence needs well under a thousand
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic xfer(input logic [7:0] a, input logic w, input logic [7:0] d);
    // Callers may return off the edge after a settled check
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= I2CSE_HTRANS_NONSEQ;
    haddr  <= a;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= I2CSE_HTRANS_IDLE;
    hsel   <= 1'b0;
    hwdata <= {24'h0, d};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd_data = hrdata;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    xfer(a, 1'b0, 8'h00);
    `CHK(rd_data, {24'h0, e})
  endtask
  // Outputs are registered from flags, so let two more edges land
  task automatic pulse(input int i);
    @(posedge hclk);
    ev[i] <= 1'b1;
    @(posedge hclk);
    ev <= '0;
    repeat (2) @(posedge hclk);
    #1;
  endtask
  // Registered outputs are read just after the edge that launches them
  task automatic settle();
    @(posedge hclk);
    #1;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {hresetn, hsel, hwrite, halt_mode, wait_mode, cpu_imask} = '0;
    {haddr, rx_addr_byte, htrans, hwdata, ev, own_addr_hit, err_pend} = '0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    rd_chk(I2CSE_OFS_CTRL, I2CSE_RST_VAL);
    rd_chk(I2CSE_OFS_STAT, I2CSE_RST_VAL);
    rd_chk(8'h08, 8'h00);
    xfer(I2CSE_OFS_CTRL, 1'b1, 8'h3d);
    rd_chk(I2CSE_OFS_CTRL, 8'h20);
    xfer(I2CSE_OFS_CTRL, 1'b1, 8'h35);
    rd_chk(I2CSE_OFS_CTRL, 8'h35);
    wait_mode <= 1'b1;
    pulse(0);
    `CHK(ack_en, 1'b1)
    `CHK(gc_en, 1'b1)
    `CHK(scl_oe_n, 1'b0)
    `CHK(irq, 1'b1)
    `CHK(wexit, 1'b1)
    cpu_imask <= 1'b1;
    pulse(1);
    `CHK(irq, 1'b0)
    cpu_imask <= 1'b0;
    rd_chk(I2CSE_OFS_STAT, 8'hc1);
    pulse(11);
    rd_chk(I2CSE_OFS_STAT, 8'hc0);
    pulse(13);
    pulse(11);
    rd_chk(I2CSE_OFS_STAT, 8'h00);
    pulse(4);
    rd_chk(I2CSE_OFS_STAT, 8'h88);
    pulse(12);
    rd_chk(I2CSE_OFS_STAT, 8'h00);
    pulse(3);
    rd_chk(I2CSE_OFS_STAT, 8'ha8);
    pulse(11);
    rd_chk(I2CSE_OFS_STAT, 8'h00);
    peer.start_cond();
    repeat (10) @(posedge hclk);
    rd_chk(I2CSE_OFS_STAT, 8'h10);
    peer.stop_cond();
    repeat (10) @(posedge hclk);
    rd_chk(I2CSE_OFS_STAT, 8'h00);
    peer.start_cond();
    repeat (10) @(posedge hclk);
    pulse(10);
    rd_chk(I2CSE_OFS_STAT, 8'h00);
    peer.stop_cond();
    repeat (10) @(posedge hclk);
    rx_addr_byte <= I2CSE_IGNORE_BYTE;
    own_addr_hit <= 1'b1;
    pulse(5);
    rd_chk(I2CSE_OFS_STAT, 8'h00);
    rx_addr_byte <= I2CSE_GCALL_BYTE;
    own_addr_hit <= 1'b0;
    pulse(5);
    rd_chk(I2CSE_OFS_STAT, 8'h84);
    rd_chk(I2CSE_OFS_STAT, 8'h00);
    settle();
    `CHK(rx_only, 1'b1)
    `CHK(alt, 1'b1)
    `CHK(scl_o, 1'b0)
    `CHK(hresp, I2CSE_HRESP_OKAY)
    xfer(I2CSE_OFS_CTRL, 1'b1, 8'h3d);
    rd_chk(I2CSE_OFS_STAT, 8'h02);
    settle();
    `CHK(start_req, 1'b1)
    `CHK(rx_only, 1'b0)
    pulse(0);
    `CHK(start_req, 1'b0)
    rd_chk(I2CSE_OFS_CTRL, 8'h35);
    rd_chk(I2CSE_OFS_STAT, 8'h83);
    pulse(11);
    pulse(2);
    `CHK(scl_oe_n, 1'b0)
    pulse(3);
    rd_chk(I2CSE_OFS_STAT, 8'h82);
    xfer(I2CSE_OFS_CTRL, 1'b1, 8'h35);
    rd_chk(I2CSE_OFS_STAT, 8'haa);
    pulse(11);
    xfer(I2CSE_OFS_CTRL, 1'b1, 8'h37);
    settle();
    `CHK(stop_req, 1'b1)
    pulse(6);
    rd_chk(I2CSE_OFS_CTRL, 8'h35);
    pulse(9);
    pulse(4);
    xfer(I2CSE_OFS_CTRL, 1'b1, 8'h37);
    settle();
    `CHK(rel, 1'b1)
    `CHK(stop_req, 1'b0)
    xfer(I2CSE_OFS_CTRL, 1'b1, 8'h35);
    rd_chk(I2CSE_OFS_STAT, 8'h88);
    pulse(12);
    `CHK(rel, 1'b0)
    `CHK(scl_oe_n, 1'b1)
    err_pend <= 1'b1;
    pulse(7);
    rd_chk(I2CSE_OFS_STAT, 8'h80);
    pulse(13);
    rd_chk(I2CSE_OFS_STAT, 8'h00);
    err_pend <= 1'b0;
    halt_mode <= 1'b1;
    pulse(4);
    `CHK(eng, 1'b0)
    xfer(I2CSE_OFS_CTRL, 1'b1, 8'h00);
    rd_chk(I2CSE_OFS_CTRL, 8'h35);
    halt_mode <= 1'b0;
    xfer(I2CSE_OFS_CTRL, 1'b1, 8'h02);
    rd_chk(I2CSE_OFS_CTRL, 8'h02);
    pulse(6);
    `CHK(alt, 1'b0)
    `CHK(rel, 1'b1)
    end_sim();
  end
endmodule
